// file: hdl/pnp_port_regs.sv
// pnp_port_regs: per-port next-page transmit, partner next-page and port configuration registers.
// assumes the negotiation engine supplies page pulses and the line side consumes the mode outputs.
//
// Behaviour
// - transmit bit 15: more pages, reset 0
// - bit 13 message page reset 1; code reset 1
// - bit 12 second acknowledge, writable, reset 0
// - bit 11 toggle inverts after each sent page
// - latched link status reloads live on read; page received clears on read
// - partner bit 15: partner has more pages
// - partner bit 14: partner acknowledged our word
// - partner bit 13 message page; code resets 0
// - partner bit 12: partner can comply
// - partner bit 11: partner toggle value
// - config bit 14 forces link pass
// - config bit 13 turns transmitter off
// - config bit 12 bypasses scrambling at 100 on twisted pair
// - config bit 11 bypasses block coding at 100 on twisted pair
// - config bit 9 enables heartbeat at 10
// - config bit 8 suppresses 10 half-duplex loopback
// - config bit 0 loaded from strap
// - config bit 0 selects fiber or twisted pair
// - page received clears on read or alt events
`timescale 1ns/100ps
`default_nettype none
module pnp_port_regs (
	input  wire logic        clk,
	input  wire logic        reset_n,
	input  wire logic        mdc,
	input  wire logic        mdio_in,
	output logic             mdio_out,
	output logic             mdio_oe,
	input  wire logic [4:0]  phy_addr,
	input  wire logic        media_select_strap,
	input  wire logic        link_raw,
	input  wire logic        speed_100,
	input  wire logic        full_duplex,
	input  wire logic        partner_page_load,
	input  wire logic [15:0] partner_page_word,
	input  wire logic        page_rx_var,
	input  wire logic        tx_page_sent,
	output logic [15:0]      np_tx_word,
	output logic             link_pass,
	output logic             tx_disable,
	output logic             scramble_bypass,
	output logic             coding_bypass,
	output logic             jabber_disable,
	output logic             heartbeat_test,
	output logic             tp_loopback,
	output logic             fiber_mode,
	output logic             alt_next_page
);
	pnp_reg_if bus ();

	logic [15:0] np_tx;
	logic [15:0] np_rx;
	logic [15:0] cfg;
	logic        fiber_sel;
	logic        strap_armed;
	logic        link_latch_low;
	logic        page_rx_latch_high;

	// serial management engine; all register traffic enters here
	pnp_mdio_slave u_mdio (
		.clk      (clk),
		.reset_n  (reset_n),
		.mdc      (mdc),
		.mdio_in  (mdio_in),
		.phy_addr (phy_addr),
		.mdio_out (mdio_out),
		.mdio_oe  (mdio_oe),
		.bus      (bus.engine)
	);

	// address decode of the single-cycle strobes
	wire wr_np_tx    = bus.wr && (bus.addr == pnp_pkg::REG_NP_TX);
	wire wr_cfg      = bus.wr && (bus.addr == pnp_pkg::REG_PORT_CFG);
	wire rd_link     = bus.rd && (bus.addr == pnp_pkg::REG_LINK_STATUS);
	wire rd_expand   = bus.rd && (bus.addr == pnp_pkg::REG_EXPANSION);

	// live link condition; forcing overrides the link test result
	wire link_live   = link_raw | cfg[pnp_pkg::CFG_LINK_FORCE];

	// alternate next-page clearing of the page received flag
	wire alt_clear   = cfg[pnp_pkg::CFG_ALT_NP] &
	                   (~page_rx_var | cfg[pnp_pkg::CFG_TX_OFF]);

	// config word as read back; reserved bits are never stored
	wire [15:0] cfg_view = (cfg & pnp_pkg::CFG_WMASK) | {15'h0000, fiber_sel};

	// read mux; unmapped addresses read zero
	function automatic logic [15:0] read_word(input logic [4:0] a,
	                                          input logic [15:0] tx,
	                                          input logic [15:0] rx,
	                                          input logic [15:0] cf,
	                                          input logic        lk,
	                                          input logic        pg);
		logic [15:0] w;
		w = 16'h0000;
		case (a)
			pnp_pkg::REG_LINK_STATUS: w[pnp_pkg::LINK_STATUS_BIT] = lk;
			pnp_pkg::REG_EXPANSION:   w[pnp_pkg::PAGE_RX_BIT]     = pg;
			pnp_pkg::REG_NP_TX:       w = tx & pnp_pkg::NP_TX_WMASK;
			pnp_pkg::REG_NP_RX:       w = rx;
			pnp_pkg::REG_PORT_CFG:    w = cf;
			default:                  w = 16'h0000;
		endcase
		return w;
	endfunction : read_word

	assign bus.rdata = read_word(bus.addr, np_tx, np_rx, cfg_view, link_latch_low, page_rx_latch_high);

	// next values of the transmit next-page word
	wire [15:0] np_tx_written = (bus.wdata & pnp_pkg::NP_TX_WMASK) |
	                            (np_tx & ~pnp_pkg::NP_TX_WMASK);
	wire [15:0] np_tx_base    = wr_np_tx ? np_tx_written : np_tx;
	wire        next_toggle   = tx_page_sent ? ~np_tx[pnp_pkg::NP_TOGGLE] :
	                            np_tx_base[pnp_pkg::NP_TOGGLE];
	wire [15:0] next_np_tx    = {np_tx_base[15:12], next_toggle, np_tx_base[10:0]};

	// transmit word; a page sent in the same cycle as a write decides the toggle,
	// because the next word must carry the inverse of what went on the wire
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			np_tx <= pnp_pkg::NP_TX_RESET;
		else
			np_tx <= next_np_tx;
	end

	// partner next-page word, loaded whole when the engine accepts a page
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			np_rx <= pnp_pkg::NP_RX_RESET;
		else if (partner_page_load)
			np_rx <= partner_page_word;
	end

	// configuration bits other than the media select; reserved bits stay zero
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			cfg <= pnp_pkg::CFG_RESET;
		else if (wr_cfg)
			cfg <= bus.wdata & pnp_pkg::CFG_WMASK;
	end

	// media select: the strap is caught on the first edge after release, never
	// inside the asynchronous reset, so the flop only ever resets to a constant
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			strap_armed <= 1'b1;
			fiber_sel   <= 1'b0;
		end else if (strap_armed) begin
			strap_armed <= 1'b0;
			fiber_sel   <= media_select_strap;
		end else if (wr_cfg) begin
			fiber_sel   <= bus.wdata[pnp_pkg::CFG_FIBER];
		end
	end

	// link status latches low; a read reloads it with the live value,
	// so a drop in the read cycle itself is still reported next time
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			link_latch_low <= 1'b0;
		else if (rd_link)
			link_latch_low <= link_live;
		else
			link_latch_low <= link_latch_low & link_live;
	end

	// page received latches high; a new page beats any clear in the same cycle
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			page_rx_latch_high <= 1'b0;
		else if (partner_page_load)
			page_rx_latch_high <= 1'b1;
		else if (rd_expand || alt_clear)
			page_rx_latch_high <= 1'b0;
	end

	// mode outputs; speed and media qualify the 100 and 10 only controls
	wire tp_mode          = ~fiber_sel;
	wire next_scr_bypass  = cfg[pnp_pkg::CFG_SCR_BYPASS] & speed_100 & tp_mode;
	wire next_code_bypass = cfg[pnp_pkg::CFG_CODE_BYPASS] & speed_100 & tp_mode;
	wire next_heartbeat   = cfg[pnp_pkg::CFG_HEARTBEAT] & ~speed_100;
	wire next_jabber_off  = cfg[pnp_pkg::CFG_JABBER_OFF] & ~speed_100;
	wire next_loopback    = ~cfg[pnp_pkg::CFG_LOOP_OFF] & ~speed_100 & ~full_duplex & tp_mode;

	// registered outputs, one cycle behind their sources
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			np_tx_word      <= pnp_pkg::NP_TX_RESET;
			link_pass       <= 1'b0;
			tx_disable      <= 1'b0;
			scramble_bypass <= 1'b0;
			coding_bypass   <= 1'b0;
			jabber_disable  <= 1'b0;
			heartbeat_test  <= 1'b0;
			tp_loopback     <= 1'b0;
			fiber_mode      <= 1'b0;
			alt_next_page   <= 1'b0;
		end else begin
			np_tx_word      <= np_tx & pnp_pkg::NP_TX_WMASK;
			link_pass       <= link_live;
			tx_disable      <= cfg[pnp_pkg::CFG_TX_OFF];
			scramble_bypass <= next_scr_bypass;
			coding_bypass   <= next_code_bypass;
			jabber_disable  <= next_jabber_off;
			heartbeat_test  <= next_heartbeat;
			tp_loopback     <= next_loopback;
			fiber_mode      <= fiber_sel;
			alt_next_page   <= cfg[pnp_pkg::CFG_ALT_NP];
		end
	end

	// checks on the bank behaviour
	a_toggle_flips: assert property (@(posedge clk) disable iff (!reset_n)
		tx_page_sent |=> (np_tx[pnp_pkg::NP_TOGGLE] != $past(np_tx[pnp_pkg::NP_TOGGLE])))
		else $error("toggle did not invert after a sent page");

	a_reserved_zero: assert property (@(posedge clk) disable iff (!reset_n)
		(np_tx[pnp_pkg::NP_ACK] == 1'b0) && (cfg[15] == 1'b0) && (cfg_view[7:2] == 6'h00))
		else $error("reserved bit holds a one");

	a_partner_load: assert property (@(posedge clk) disable iff (!reset_n)
		partner_page_load |=> (np_rx == $past(partner_page_word)) ##1 (np_rx == $past(partner_page_word, 2)) || $past(partner_page_load))
		else $error("partner word not captured");

	a_page_set_wins: assert property (@(posedge clk) disable iff (!reset_n)
		(partner_page_load && rd_expand) |=> page_rx_latch_high)
		else $error("page received lost to a read");

	a_page_read_clear: assert property (@(posedge clk) disable iff (!reset_n)
		(rd_expand && !partner_page_load) |=> !page_rx_latch_high)
		else $error("page received not cleared on read");

	a_link_force: assert property (@(posedge clk) disable iff (!reset_n)
		cfg[pnp_pkg::CFG_LINK_FORCE] [*2] |=> link_pass ##1 link_pass || !$past(cfg[pnp_pkg::CFG_LINK_FORCE]))
		else $error("forced link not passing");

	a_link_latch: assert property (@(posedge clk) disable iff (!reset_n)
		(!link_live && !rd_link) |=> !link_latch_low)
		else $error("link drop not latched");

	a_strap_load: assert property (@(posedge clk)
		$rose(reset_n) |-> ##1 (fiber_sel == $past(media_select_strap)) ##1 (fiber_mode == $past(fiber_sel)))
		else $error("media select not taken from strap");

	a_loopback_mode: assert property (@(posedge clk) disable iff (!reset_n)
		(speed_100 || full_duplex) |=> !tp_loopback)
		else $error("loopback outside ten half duplex");

	a_heartbeat_10: assert property (@(posedge clk) disable iff (!reset_n)
		speed_100 |=> !heartbeat_test)
		else $error("heartbeat active at hundred");

endmodule : pnp_port_regs
`default_nettype wire

// file: hdl/pnp_pkg.sv
// pnp_pkg: constants, register map and state encodings for the next-page and port configuration slice.
// assumes one 10 MHz register clock; the management frame arrives on mdc and mdio as synchronous inputs.
package pnp_pkg;

	// register addresses on the management interface
	localparam logic [4:0] REG_LINK_STATUS = 5'h01;
	localparam logic [4:0] REG_EXPANSION   = 5'h06;
	localparam logic [4:0] REG_NP_TX       = 5'h07;
	localparam logic [4:0] REG_NP_RX       = 5'h08;
	localparam logic [4:0] REG_PORT_CFG    = 5'h10;

	// next-page word field positions (shared by transmit and partner words)
	localparam int NP_FURTHER  = 15;
	localparam int NP_ACK      = 14;
	localparam int NP_MESSAGE  = 13;
	localparam int NP_SECOND_ACKNOWLEDGE     = 12;
	localparam int NP_TOGGLE   = 11;
	localparam int NP_CODE_MSB = 10;

	// reset values and writable masks
	localparam logic [15:0] NP_TX_RESET = 16'h2001;
	localparam logic [15:0] NP_TX_WMASK = 16'hbfff;
	localparam logic [15:0] NP_RX_RESET = 16'h0000;
	localparam logic [15:0] CFG_RESET   = 16'h0000;
	localparam logic [15:0] CFG_WMASK   = 16'h7f02;

	// port configuration bit positions
	localparam int CFG_LINK_FORCE = 14;
	localparam int CFG_TX_OFF     = 13;
	localparam int CFG_SCR_BYPASS = 12;
	localparam int CFG_CODE_BYPASS = 11;
	localparam int CFG_JABBER_OFF = 10;
	localparam int CFG_HEARTBEAT  = 9;
	localparam int CFG_LOOP_OFF   = 8;
	localparam int CFG_ALT_NP     = 1;
	localparam int CFG_FIBER      = 0;

	// status bit positions
	localparam int LINK_STATUS_BIT = 2;
	localparam int PAGE_RX_BIT     = 1;

	// management frame constants
	localparam logic [5:0] MDIO_PREAMBLE = 6'h20;
	localparam logic [4:0] MDIO_HDR_LAST = 5'h0d;
	localparam logic [4:0] MDIO_DAT_LAST = 5'h0f;
	localparam logic [1:0] MDIO_START    = 2'h1;
	localparam logic [1:0] MDIO_OP_READ  = 2'h2;
	localparam logic [1:0] MDIO_OP_WRITE = 2'h1;

	typedef enum logic [1:0] {
		PNP_S_PRE  = 2'b00,
		PNP_S_HDR  = 2'b01,
		PNP_S_TA   = 2'b10,
		PNP_S_DATA = 2'b11
	} pnp_mdio_state_e;

endpackage : pnp_pkg

// file: hdl/pnp_reg_if.sv
// pnp_reg_if: register access strobes between the serial frame engine and the register bank.
// assumes both ends run on the same clock; wr and rd are one-cycle pulses.
`timescale 1ns/100ps
`default_nettype none
interface pnp_reg_if;
	logic [4:0]  addr;
	logic [15:0] wdata;
	logic        wr;
	logic        rd;
	logic [15:0] rdata;

	modport engine (output addr, output wdata, output wr, output rd, input rdata);
	modport bank   (input addr, input wdata, input wr, input rd, output rdata);
endinterface : pnp_reg_if
`default_nettype wire

// file: hdl/pnp_mdio_slave.sv
// pnp_mdio_slave: serial management frame engine for one port address.
// assumes mdc is far slower than clk so every mdc rising edge is seen; data is driven after each rising edge.
`timescale 1ns/100ps
`default_nettype none
module pnp_mdio_slave (
	input  wire logic        clk,
	input  wire logic        reset_n,
	input  wire logic        mdc,
	input  wire logic        mdio_in,
	input  wire logic [4:0]  phy_addr,
	output logic             mdio_out,
	output logic             mdio_oe,
	pnp_reg_if.engine        bus
);
	pnp_pkg::pnp_mdio_state_e state;
	logic [5:0]  ones;
	logic [4:0]  count;
	logic [15:0] shift;
	logic        mdc_q;
	logic        is_read;

	// header decode of the 14 bits start, op, port address and register address
	wire         rise      = mdc & ~mdc_q;
	wire  [13:0] hdr       = {shift[12:0], mdio_in};
	wire         hdr_ok    = (hdr[13:12] == pnp_pkg::MDIO_START) && (hdr[9:5] == phy_addr);
	wire         hdr_read  = hdr_ok && (hdr[11:10] == pnp_pkg::MDIO_OP_READ);
	wire         hdr_write = hdr_ok && (hdr[11:10] == pnp_pkg::MDIO_OP_WRITE);

	// frame engine; a frame for another port falls back to preamble hunting
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state        <= pnp_pkg::PNP_S_PRE;
			ones         <= 6'h00;
			count        <= 5'h00;
			shift        <= 16'h0000;
			mdc_q        <= 1'b0;
			is_read      <= 1'b0;
			mdio_out     <= 1'b0;
			mdio_oe      <= 1'b0;
			bus.addr     <= 5'h00;
			bus.wdata    <= 16'h0000;
			bus.wr       <= 1'b0;
			bus.rd       <= 1'b0;
		end else begin
			mdc_q        <= mdc;
			bus.wr       <= 1'b0;
			bus.rd       <= 1'b0;
			// read data is taken on the strobe edge itself; one edge later the
			// latched status bits have already been cleared or reloaded by the read
			if (bus.rd)
				shift <= bus.rdata;
			if (rise) begin
				case (state)
					pnp_pkg::PNP_S_PRE: begin
						if (mdio_in) begin
							if (ones != pnp_pkg::MDIO_PREAMBLE)
								ones <= ones + 6'h01;
						end else if (ones == pnp_pkg::MDIO_PREAMBLE) begin
							state <= pnp_pkg::PNP_S_HDR;
							count <= 5'h01;
							shift <= 16'h0000;
						end else begin
							ones <= 6'h00;
						end
					end
					pnp_pkg::PNP_S_HDR: begin
						shift <= {shift[14:0], mdio_in};
						count <= count + 5'h01;
						if (count == pnp_pkg::MDIO_HDR_LAST) begin
							ones     <= 6'h00;
							count    <= 5'h00;
							bus.addr <= hdr[4:0];
							is_read  <= hdr_read;
							bus.rd   <= hdr_read;
							state    <= (hdr_read || hdr_write) ? pnp_pkg::PNP_S_TA : pnp_pkg::PNP_S_PRE;
						end
					end
					pnp_pkg::PNP_S_TA: begin
						count <= count + 5'h01;
						if (count == 5'h00) begin
							mdio_oe  <= is_read;
							mdio_out <= 1'b0;
						end else begin
							mdio_out <= is_read & shift[15];
							shift    <= is_read ? {shift[14:0], 1'b0} : shift;
							count    <= 5'h00;
							state    <= pnp_pkg::PNP_S_DATA;
						end
					end
					pnp_pkg::PNP_S_DATA: begin
						count <= count + 5'h01;
						if (is_read) begin
							mdio_out <= shift[15];
							shift    <= {shift[14:0], 1'b0};
						end else begin
							shift <= {shift[14:0], mdio_in};
						end
						if (count == pnp_pkg::MDIO_DAT_LAST) begin
							mdio_oe   <= 1'b0;
							mdio_out  <= 1'b0;
							bus.wdata <= {shift[14:0], mdio_in};
							bus.wr    <= ~is_read;
							count     <= 5'h00;
							state     <= pnp_pkg::PNP_S_PRE;
						end
					end
					default: begin
						state <= pnp_pkg::PNP_S_PRE;
					end
				endcase
			end
		end
	end

endmodule : pnp_mdio_slave
`default_nettype wire

// file: verification/pnp_mdio_station.sv
// pnp_mdio_station: management station on the far side of the serial register port.
// assumes clk is the design's clock; mdc is made from it, two clocks low and two high per bit.
`timescale 1ns/100ps
`default_nettype none
module pnp_mdio_station (
	input  wire logic clk,
	input  wire logic mdio_out,
	input  wire logic mdio_oe,
	output logic      mdc,
	output logic      mdio_in
);
	logic drv_en;
	logic drv_bit;

	// shared line with pull-up: a released line reads high, never a stale value
	assign mdio_in = (drv_en ? drv_bit : 1'b1) & (mdio_oe ? mdio_out : 1'b1);

	initial begin
		mdc = 1'b0;
		drv_en = 1'b0;
		drv_bit = 1'b1;
	end

	// one bit: data set while mdc low, line sampled just before the rise
	task automatic cycle(input logic en, input logic b, output logic seen);
		mdc = 1'b0;
		drv_en = en;
		drv_bit = b;
		repeat (2) @(posedge clk);
		#1;
		seen = mdio_in;
		mdc = 1'b1;
		repeat (2) @(posedge clk);
		#1;
	endtask : cycle

	// whole frame; own preamble each time, line released on read turnaround
	task automatic frame(input logic rd, input logic [4:0] pa, input logic [4:0] ra,
	                     input logic [15:0] wd, output logic [15:0] rdat, output logic ta);
		logic [13:0] hdr;
		logic        s;
		hdr = {2'b01, (rd ? 2'b10 : 2'b01), pa, ra};
		@(posedge clk);
		#1;
		for (int i = 0; i < 32; i++) cycle(1'b1, 1'b1, s);
		for (int i = 13; i >= 0; i--) cycle(1'b1, hdr[i], s);
		cycle(!rd, 1'b1, s);
		cycle(!rd, 1'b0, ta);
		for (int i = 15; i >= 0; i--) begin
			cycle(!rd, wd[i], s);
			rdat[i] = s;
		end
		// clock stands still low between frames; let the write land
		mdc = 1'b0;
		drv_en = 1'b0;
		repeat (3) @(posedge clk);
		#1;
	endtask : frame
endmodule : pnp_mdio_station
`default_nettype wire

// file: verification/pnp_port_regs_tb_top.sv
// pnp_port_regs_tb_top: self-checking bench for the next-page and port configuration registers.
// assumes the station model supplies all register traffic; side inputs are driven here.
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin failures++; \
	$display("mismatch %s expected %h seen %h", nm, e, g); end end
module pnp_port_regs_tb_top;
	localparam logic [4:0] PHY = 5'h03;
	logic        clk;
	logic        reset_n;
	logic        mdc;
	logic        mdio_in;
	logic        mdio_out;
	logic        mdio_oe;
	logic        strap;
	logic        link_raw;
	logic        speed_100;
	logic        full_duplex;
	logic        page_load;
	logic [15:0] page_word;
	logic        page_rx_var;
	logic        page_sent;
	logic [15:0] np_tx_word;
	logic        link_pass;
	logic        tx_disable;
	logic        scramble_bypass;
	logic        coding_bypass;
	logic        jabber_disable;
	logic        heartbeat_test;
	logic        tp_loopback;
	logic        fiber_mode;
	logic        alt_next_page;
	int          failures;
	int          checks_done;

	pnp_port_regs u_pnp_port_regs (.clk(clk), .reset_n(reset_n), .mdc(mdc), .mdio_in(mdio_in),
		.mdio_out(mdio_out), .mdio_oe(mdio_oe), .phy_addr(PHY), .media_select_strap(strap),
		.link_raw(link_raw), .speed_100(speed_100), .full_duplex(full_duplex),
		.partner_page_load(page_load), .partner_page_word(page_word), .page_rx_var(page_rx_var),
		.tx_page_sent(page_sent), .np_tx_word(np_tx_word), .link_pass(link_pass),
		.tx_disable(tx_disable), .scramble_bypass(scramble_bypass), .coding_bypass(coding_bypass),
		.jabber_disable(jabber_disable), .heartbeat_test(heartbeat_test), .tp_loopback(tp_loopback),
		.fiber_mode(fiber_mode), .alt_next_page(alt_next_page));

	pnp_mdio_station u_pnp_mdio_station (.clk(clk), .mdio_out(mdio_out), .mdio_oe(mdio_oe),
		.mdc(mdc), .mdio_in(mdio_in));

	// 100 ns clock
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	task automatic final_report;
		$display("checks %0d mismatches %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : final_report

	// about 26 frames of 260 clocks each; over four times that is a hang
	initial begin
		#3000000;
		failures++;
		final_report();
	end

	task automatic do_reset(input logic s);
		reset_n = 1'b0;
		strap = s;
		repeat (6) @(posedge clk);
		#1;
		reset_n = 1'b1;
		repeat (3) @(posedge clk);
		#1;
	endtask : do_reset

	task automatic wr(input logic [4:0] ra, input logic [15:0] d);
		logic [15:0] x;
		logic        t;
		u_pnp_mdio_station.frame(1'b0, PHY, ra, d, x, t);
	endtask : wr

	task automatic rchk(input logic [4:0] ra, input logic [15:0] e, input string nm);
		logic [15:0] d;
		logic        t;
		u_pnp_mdio_station.frame(1'b1, PHY, ra, 16'h0000, d, t);
		`CHK(nm, e, d)
	endtask : rchk

	// single-cycle pulses from the negotiation side
	task automatic pulse_load(input logic [15:0] w);
		page_word = w;
		page_load = 1'b1;
		@(posedge clk);
		#1;
		page_load = 1'b0;
		@(posedge clk);
		#1;
	endtask : pulse_load

	task automatic pulse_sent;
		page_sent = 1'b1;
		@(posedge clk);
		#1;
		page_sent = 1'b0;
		@(posedge clk);
		#1;
	endtask : pulse_sent

	initial begin
		logic [15:0] d;
		logic        t;
		reset_n = 1'b0;
		strap = 1'b0;
		link_raw = 1'b1;
		speed_100 = 1'b0;
		full_duplex = 1'b0;
		page_load = 1'b0;
		page_word = 16'h0000;
		page_rx_var = 1'b0;
		page_sent = 1'b0;
		failures = 0;
		checks_done = 0;
		do_reset(1'b0);
		`CHK("np_tx_word", 16'h2001, np_tx_word)
		u_pnp_mdio_station.frame(1'b1, PHY, 5'h07, 16'h0000, d, t);
		`CHK("tx word", 16'h2001, d)
		`CHK("turnaround", 1'b0, t)
		`CHK("mdio_oe", 1'b0, mdio_oe)
		rchk(5'h08, 16'h0000, "partner word");
		rchk(5'h10, 16'h0000, "config");
		`CHK("fiber_mode", 1'b0, fiber_mode)
		$display("test reset_values done");
		wr(5'h07, 16'hffff);
		rchk(5'h07, 16'hbfff, "tx word");
		`CHK("np_tx_word", 16'hbfff, np_tx_word)
		wr(5'h07, 16'h0000);
		rchk(5'h07, 16'h0000, "tx word");
		pulse_sent();
		rchk(5'h07, 16'h0800, "tx word");
		pulse_sent();
		rchk(5'h07, 16'h0000, "tx word");
		$display("test transmit_word done");
		pulse_load(16'hdaaa);
		wr(5'h08, 16'h0000);
		rchk(5'h08, 16'hdaaa, "partner word");
		rchk(5'h06, 16'h0002, "page received");
		rchk(5'h06, 16'h0000, "page received");
		pulse_load(16'h2555);
		rchk(5'h08, 16'h2555, "partner word");
		wr(5'h10, 16'h0002);
		page_rx_var = 1'b1;
		pulse_load(16'h0001);
		page_rx_var = 1'b0;
		repeat (3) @(posedge clk);
		#1;
		rchk(5'h06, 16'h0000, "page received");
		$display("test partner_word done");
		// the latch has held low since reset; this read reloads it with the live pass
		rchk(5'h01, 16'h0000, "link status");
		link_raw = 1'b0;
		repeat (3) @(posedge clk);
		#1;
		link_raw = 1'b1;
		rchk(5'h01, 16'h0000, "link status");
		rchk(5'h01, 16'h0004, "link status");
		$display("test latch_low done");
		speed_100 = 1'b1;
		link_raw = 1'b0;
		wr(5'h10, 16'hfffe);
		rchk(5'h10, 16'h7f02, "config");
		`CHK("link_pass", 1'b1, link_pass)
		`CHK("tx_disable", 1'b1, tx_disable)
		`CHK("scramble_bypass", 1'b1, scramble_bypass)
		`CHK("coding_bypass", 1'b1, coding_bypass)
		`CHK("heartbeat_test", 1'b0, heartbeat_test)
		`CHK("jabber_disable", 1'b0, jabber_disable)
		speed_100 = 1'b0;
		repeat (3) @(posedge clk);
		#1;
		`CHK("heartbeat_test", 1'b1, heartbeat_test)
		`CHK("scramble_bypass", 1'b0, scramble_bypass)
		`CHK("coding_bypass", 1'b0, coding_bypass)
		`CHK("tp_loopback", 1'b0, tp_loopback)
		`CHK("jabber_disable", 1'b1, jabber_disable)
		`CHK("alt_next_page", 1'b1, alt_next_page)
		wr(5'h10, 16'h0000);
		`CHK("link_pass", 1'b0, link_pass)
		`CHK("tx_disable", 1'b0, tx_disable)
		`CHK("heartbeat_test", 1'b0, heartbeat_test)
		`CHK("tp_loopback", 1'b1, tp_loopback)
		`CHK("jabber_disable", 1'b0, jabber_disable)
		`CHK("alt_next_page", 1'b0, alt_next_page)
		full_duplex = 1'b1;
		repeat (3) @(posedge clk);
		#1;
		`CHK("tp_loopback", 1'b0, tp_loopback)
		$display("test config_outputs done");
		rchk(5'h1f, 16'h0000, "unmapped");
		u_pnp_mdio_station.frame(1'b1, PHY ^ 5'h01, 5'h07, 16'h0000, d, t);
		`CHK("other port", 16'hffff, d)
		`CHK("mdio_oe", 1'b0, mdio_oe)
		$display("test refusals done");
		do_reset(1'b1);
		rchk(5'h10, 16'h0001, "config");
		`CHK("fiber_mode", 1'b1, fiber_mode)
		rchk(5'h07, 16'h2001, "tx word");
		$display("test strap_reset done");
		final_report();
	end
endmodule : pnp_port_regs_tb_top
`default_nettype wire
